// [rtl/deenvm_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - after a good unlock the control register accepts one write, next cycle only
// - key register is write-only, reads return zero; it only guards the control register
// - start bit bit 15 is set by software, cleared by hardware at completion
// - enable bit 14 must be set to run; cleared by hardware at completion
// - error bit 13 set when a pin or watchdog reset aborts a cycle
// - skip-erase bit 12 clear means erase target before writing it
// - erase select bit 6: one erases, zero writes
// - command 011010 erases eight words, 011001 four, 011000 one
// - command 0100xx with erase selected erases the whole array
// - command 0001xx with write selected programs one latched word
// - address of the last table write is captured internally, not mapped
// - captured address splits into 8-bit high and 16-bit low parts
// - low address bit always reads zero
// - top bit of the high address part always reads zero
// - array is 16 bits wide; a low-word table read returns one word
// - completion of erase or write sets the interrupt flag
// - table accesses only accepted inside the array's address window
// - the array holds 256 sixteen-bit words
module deenvm_ctrl #(
   parameter int WORDS = deenvm_pkg::EE_WORDS,
   parameter int CELL_CYC = deenvm_pkg::CELL_CYCLES
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic abort_reset_i, // pin or watchdog reset pulse
   // special register write port
   input wire logic sfr_wr_i,
   input wire logic [1:0] sfr_sel_i,
   input wire logic [15:0] sfr_wdata_i,
   // table access port
   input wire logic tbl_wr_i,
   input wire logic tbl_rd_i,
   input wire logic [23:0] tbl_addr_i,
   input wire logic [15:0] tbl_wdata_i,
   // outputs
   output logic [15:0] nvm_control_o,
   output logic [15:0] tbl_rdata_o,
   output logic tbl_rvalid_o,
   output logic nvm_irq_flag_o,
   output logic [7:0] addr_high_o,
   output logic [15:0] addr_low_o
);
   import deenvm_pkg::*;

   localparam int AW = $clog2(WORDS);
   localparam int CW = $clog2(CELL_CYC + 1);

   // the address window and the word index are sized for exactly 256 words
   generate
      if (WORDS != 256 || CELL_CYC < 1) begin : g_bad_params
         $error("unsupported parameters");
      end
   endgenerate

   logic [15:0] nvm_control_reg;
   logic [7:0] addr_high_reg;
   logic [15:0] addr_low_reg;
   logic [15:0] latch_reg;
   logic [15:0] mem_reg [WORDS];
   logic key1_reg;
   logic window_reg;
   dee_state_t state_reg;
   logic [CW-1:0] cnt_reg;
   logic [AW-1:0] base_reg;
   logic [AW-1:0] span_reg;
   logic [15:0] tbl_rdata_reg;
   logic tbl_rvalid_reg;
   logic irq_reg;

   // array index from a byte address; the low bit is dropped
   function automatic logic [AW-1:0] word_idx(input logic [23:0] a);
      return a[AW:1];
   endfunction

   function automatic logic in_window(input logic [23:0] a);
      return (a >= EE_BASE) && (a <= EE_TOP);
   endfunction

   // decode the command field into the number of words minus one to erase
   function automatic logic [AW-1:0] erase_span(input logic [5:0] op);
      case (op)
         OP_ERASE8: return AW'(7);
         OP_ERASE4: return AW'(3);
         OP_ERASE1: return AW'(0);
         default: return '1; // bulk covers every word
      endcase
   endfunction

   wire logic [5:0] op = nvm_control_reg[5:0];
   wire logic erase_sel = nvm_control_reg[ERASE_SEL_BIT];
   wire logic is_bulk = op[5:2] == OP_BULK_TOP;
   wire logic is_part = (op == OP_ERASE8) || (op == OP_ERASE4) || (op == OP_ERASE1);
   wire logic is_wr = op[5:2] == OP_WRITE_TOP;
   wire logic key_wr = sfr_wr_i && sfr_sel_i == SEL_KEY;
   wire logic ctl_wr = sfr_wr_i && sfr_sel_i == SEL_CONTROL && window_reg;
   wire logic start = ctl_wr && sfr_wdata_i[START_BIT] && !nvm_control_reg[START_BIT]
      && nvm_control_reg[ENABLE_BIT];
   wire logic busy = state_reg != DEE_IDLE;
   wire logic cnt_end = cnt_reg == CW'(CELL_CYC - 1);

   // unlock sequencer: any other register access between keys breaks it
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         key1_reg <= 1'b0;
         window_reg <= 1'b0;
      end else begin
         key1_reg <= key_wr && sfr_wdata_i == KEY_FIRST;
         window_reg <= key_wr && sfr_wdata_i == KEY_SECOND && key1_reg;
      end
   end

   // address capture from table writes; the write latch holds the data word
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         addr_high_reg <= 8'h00;
         addr_low_reg <= 16'h0000;
         latch_reg <= 16'h0000;
      end else if (tbl_wr_i && in_window(tbl_addr_i)) begin
         addr_high_reg <= {1'b0, tbl_addr_i[22:16]};
         addr_low_reg <= {tbl_addr_i[15:1], 1'b0};
         latch_reg <= tbl_wdata_i;
      end
   end

   // control register; hardware bits win over a software write
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         nvm_control_reg <= CONTROL_RESET;
      end else begin
         if (ctl_wr && !busy) begin
            nvm_control_reg <= (sfr_wdata_i & CONTROL_WMASK)
               | (nvm_control_reg & ~CONTROL_WMASK & ~16'h8000);
            nvm_control_reg[ERROR_BIT] <= nvm_control_reg[ERROR_BIT] & ~sfr_wdata_i[ERROR_BIT];
            nvm_control_reg[START_BIT] <= start; // software can only set
         end
         if (busy && abort_reset_i) begin
            nvm_control_reg[ERROR_BIT] <= 1'b1;
            nvm_control_reg[START_BIT] <= 1'b0;
            nvm_control_reg[ENABLE_BIT] <= 1'b0;
         end else if (state_reg == DEE_DONE) begin
            nvm_control_reg[START_BIT] <= 1'b0;
            nvm_control_reg[ENABLE_BIT] <= 1'b0;
         end
      end
   end

   // cycle sequencer: erase phase then program phase, each a fixed cell time
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         state_reg <= DEE_IDLE;
         cnt_reg <= '0;
         base_reg <= '0;
         span_reg <= '0;
      end else begin
         case (state_reg)
            DEE_IDLE: begin
               cnt_reg <= '0;
               if (start) begin
                  base_reg <= word_idx({addr_high_reg, addr_low_reg});
                  if (erase_sel && (is_part || is_bulk)) begin
                     span_reg <= erase_span(op);
                     state_reg <= DEE_ERASE;
                  end else if (!erase_sel && is_wr) begin
                     span_reg <= '0;
                     state_reg <= nvm_control_reg[SKIP_ERASE_BIT] ? DEE_PROG : DEE_ERASE;
                  end else begin
                     state_reg <= DEE_DONE; // unknown command completes with no effect
                  end
               end
            end
            DEE_ERASE: begin
               cnt_reg <= cnt_end ? '0 : cnt_reg + 1'b1;
               if (abort_reset_i) state_reg <= DEE_IDLE;
               else if (cnt_end) state_reg <= erase_sel ? DEE_DONE : DEE_PROG;
            end
            DEE_PROG: begin
               cnt_reg <= cnt_end ? '0 : cnt_reg + 1'b1;
               if (abort_reset_i) state_reg <= DEE_IDLE;
               else if (cnt_end) state_reg <= DEE_DONE;
            end
            DEE_DONE: state_reg <= DEE_IDLE;
            default: state_reg <= DEE_IDLE;
         endcase
      end
   end

   // array storage; bulk ignores the captured base, partial erases align the block
   generate
      for (genvar i = 0; i < WORDS; i++) begin : g_cell
         wire logic hit = is_bulk && erase_sel ? 1'b1
            : ((AW'(i) & ~span_reg) == (base_reg & ~span_reg));
         always_ff @(posedge ref_clk_i) begin
            if (rst_i) begin
               mem_reg[i] <= 16'hFFFF;
            end else if (hit && cnt_end && !abort_reset_i) begin
               if (state_reg == DEE_ERASE) mem_reg[i] <= 16'hFFFF;
               else if (state_reg == DEE_PROG) mem_reg[i] <= mem_reg[i] & latch_reg;
            end
         end
      end
   endgenerate

   // table read: one word, low lane only; served while busy too, returning the current array word
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         tbl_rdata_reg <= 16'h0000;
         tbl_rvalid_reg <= 1'b0;
      end else begin
         tbl_rvalid_reg <= tbl_rd_i && in_window(tbl_addr_i);
         if (tbl_rd_i && in_window(tbl_addr_i)) tbl_rdata_reg <= mem_reg[word_idx(tbl_addr_i)];
      end
   end

   // completion flag: set wins over software clearing through the key port is not offered;
   // the flag is a pulse toward the interrupt controller that holds the sticky copy
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) irq_reg <= 1'b0;
      else irq_reg <= state_reg == DEE_DONE;
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         nvm_control_o <= 16'h0000;
         addr_high_o <= 8'h00;
         addr_low_o <= 16'h0000;
      end else begin
         nvm_control_o <= nvm_control_reg; // key register never readable
         addr_high_o <= addr_high_reg;
         addr_low_o <= addr_low_reg;
      end
   end

   assign tbl_rdata_o = tbl_rdata_reg;
   assign tbl_rvalid_o = tbl_rvalid_reg;
   assign nvm_irq_flag_o = irq_reg;

   // unlock window lasts a single cycle after the second key
   unlock_once_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      window_reg |=> !window_reg) else $error("unlock window too long");
   sequence keys_s;
      key_wr && sfr_wdata_i == KEY_FIRST ##1 key_wr && sfr_wdata_i == KEY_SECOND;
   endsequence
   key_unlock_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      keys_s |=> window_reg) else $error("keys did not unlock");
   locked_ctl_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (sfr_wr_i && sfr_sel_i == SEL_CONTROL && !window_reg && !busy && state_reg == DEE_IDLE)
      |=> $stable(nvm_control_reg[12:0])) else $error("locked write took effect");
   start_clear_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      state_reg == DEE_DONE |=> !nvm_control_reg[START_BIT] && !nvm_control_reg[ENABLE_BIT])
      else $error("start not cleared");
   done_irq_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      state_reg == DEE_DONE |=> irq_reg) else $error("no completion flag");
   abort_err_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (busy && abort_reset_i) |=> nvm_control_reg[ERROR_BIT]) else $error("abort not flagged");
   no_enable_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (state_reg == DEE_IDLE && !nvm_control_reg[ENABLE_BIT]) |=> state_reg == DEE_IDLE)
      else $error("ran without enable");
   skip_erase_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (start && !erase_sel && is_wr && nvm_control_reg[SKIP_ERASE_BIT]) |=> state_reg == DEE_PROG)
      else $error("erased despite skip");
   addr_even_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      !addr_low_reg[0] && !addr_high_reg[7]) else $error("address bits not zero");
   // a control write while a cycle runs leaves the configuration alone
   busy_ctl_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (ctl_wr && busy) |=> $stable(nvm_control_reg[12:0])) else $error("write while busy");
   // an accepted start always leaves idle on the next cycle
   start_busy_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      start |=> state_reg != DEE_IDLE) else $error("start did not launch");
   // completion pulse lasts one cycle, the sticky copy lives outside
   irq_pulse_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      irq_reg |=> !irq_reg) else $error("completion pulse too long");
   // accesses outside the array window get no answer and move no address
   read_refuse_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (tbl_rd_i && !in_window(tbl_addr_i)) |=> !tbl_rvalid_reg) else $error("stray read answered");
   addr_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (tbl_wr_i && !in_window(tbl_addr_i)) |=> $stable(addr_low_reg) && $stable(addr_high_reg))
      else $error("stray write captured");
   // a read inside the window is answered on the next cycle
   read_answer_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (tbl_rd_i && in_window(tbl_addr_i)) |=> tbl_rvalid_reg) else $error("read not answered");
   // launch steps: the decoded command sets the erase span before the cell time runs
   sequence bulk_go_s;
      start && erase_sel && is_bulk;
   endsequence
   sequence erase8_go_s;
      start && erase_sel && op == OP_ERASE8;
   endsequence
   bulk_span_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      bulk_go_s |=> state_reg == DEE_ERASE && span_reg == '1) else $error("bulk not set up");
   erase8_span_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      erase8_go_s |=> state_reg == DEE_ERASE && span_reg == AW'(7)) else $error("erase8 span");
   // erase phase ends after its cell time unless an abort cuts it
   erase_end_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (state_reg == DEE_ERASE && cnt_end && !abort_reset_i) |=> state_reg != DEE_ERASE)
      else $error("erase phase overran");
endmodule
`default_nettype wire

// [common/deenvm_pkg.sv]
package deenvm_pkg;
   // register access: "documented" ports, no public bus; the core's SFR write port is modelled
   // as a strobed word write per register select
   localparam logic [1:0] SEL_CONTROL = 2'h0;
   localparam logic [1:0] SEL_KEY = 2'h1;
   // control register field positions
   localparam int START_BIT = 15;
   localparam int ENABLE_BIT = 14;
   localparam int ERROR_BIT = 13;
   localparam int SKIP_ERASE_BIT = 12;
   localparam int ERASE_SEL_BIT = 6;
   localparam logic [15:0] CONTROL_RESET = 16'h0000;
   localparam logic [15:0] CONTROL_WMASK = 16'h507F; // writable bits besides start
   // unlock keys
   localparam logic [15:0] KEY_FIRST = 16'h0055;
   localparam logic [15:0] KEY_SECOND = 16'h00AA;
   // command field codes
   localparam logic [5:0] OP_ERASE8 = 6'h1A;
   localparam logic [5:0] OP_ERASE4 = 6'h19;
   localparam logic [5:0] OP_ERASE1 = 6'h18;
   localparam logic [3:0] OP_BULK_TOP = 4'h4; // 0100xx
   localparam logic [3:0] OP_WRITE_TOP = 4'h1; // 0001xx
   // address window of the array
   localparam logic [23:0] EE_BASE = 24'h7FFE00;
   localparam logic [23:0] EE_TOP = 24'h7FFFFF;
   localparam int EE_WORDS = 256;
   // cell timing
   localparam int CLK_PERIOD_NS = 4;
   localparam int CELL_TIME_NS = 40;
   localparam int CELL_CYCLES = (CELL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   typedef enum logic [3:0] {
      DEE_IDLE = 4'b0001,
      DEE_ERASE = 4'b0010,
      DEE_PROG = 4'b0100,
      DEE_DONE = 4'b1000
   } dee_state_t;
endpackage

// [dv/deenvm_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
// core side: strobes change just after a rising edge; a table strobe lasts one cycle, a register strobe stays up until idle
module deenvm_core_model (
   // clock
   input wire logic clk_i,
   // register write port
   output logic sfr_wr_o,
   output logic [1:0] sfr_sel_o,
   output logic [15:0] sfr_wdata_o,
   // table port
   output logic tbl_wr_o,
   output logic tbl_rd_o,
   output logic [23:0] tbl_addr_o,
   output logic [15:0] tbl_wdata_o
);
   import deenvm_pkg::*;
   // quiet bus at time zero
   initial begin
      {sfr_wr_o, sfr_sel_o, sfr_wdata_o} = '0;
      {tbl_wr_o, tbl_rd_o, tbl_addr_o, tbl_wdata_o} = '0;
   end
   // one register write, strobe left high for a follow-on write
   task automatic sfr(input logic [1:0] sel, input logic [15:0] d);
      @(posedge clk_i);
      sfr_wr_o <= 1'b1;
      sfr_sel_o <= sel;
      sfr_wdata_o <= d;
   endtask
   // register write data and table address flip so stale values are never mistaken for live ones
   task automatic idle();
      @(posedge clk_i);
      sfr_wr_o <= 1'b0;
      tbl_wr_o <= 1'b0;
      tbl_rd_o <= 1'b0;
      sfr_wdata_o <= ~sfr_wdata_o;
      tbl_addr_o <= ~tbl_addr_o;
   endtask
   // keys back to back, then the control write, nothing in between
   task automatic unlock(input logic [15:0] ctrl);
      sfr(SEL_KEY, KEY_FIRST);
      sfr(SEL_KEY, KEY_SECOND);
      sfr(SEL_CONTROL, ctrl);
      idle();
   endtask
   // one table access, a whole 16-bit word
   task automatic tbl(input logic wr, input logic [23:0] a, input logic [15:0] d);
      @(posedge clk_i);
      tbl_wr_o <= wr;
      tbl_rd_o <= !wr;
      tbl_addr_o <= a;
      tbl_wdata_o <= d;
      idle();
   endtask
endmodule
`default_nettype wire

// [dv/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import deenvm_pkg::*;
   logic ref_clk_i, rst_i, abort_reset_i, sfr_wr_i, tbl_wr_i, tbl_rd_i, tbl_rvalid_o;
   logic nvm_irq_flag_o;
   logic [1:0] sfr_sel_i;
   logic [15:0] sfr_wdata_i, tbl_wdata_i, nvm_control_o, tbl_rdata_o, addr_low_o;
   logic [23:0] tbl_addr_i;
   logic [7:0] addr_high_o;
   int fail_count, num_checks, cyc, irq_cnt, irq_exp;
   deenvm_ctrl i_deenvm_ctrl (.ref_clk_i, .rst_i, .abort_reset_i, .sfr_wr_i, .sfr_sel_i,
      .sfr_wdata_i, .tbl_wr_i, .tbl_rd_i, .tbl_addr_i, .tbl_wdata_i, .nvm_control_o,
      .tbl_rdata_o, .tbl_rvalid_o, .nvm_irq_flag_o, .addr_high_o, .addr_low_o);
   deenvm_core_model i_deenvm_core_model (.clk_i(ref_clk_i), .sfr_wr_o(sfr_wr_i),
      .sfr_sel_o(sfr_sel_i), .sfr_wdata_o(sfr_wdata_i), .tbl_wr_o(tbl_wr_i),
      .tbl_rd_o(tbl_rd_i), .tbl_addr_o(tbl_addr_i), .tbl_wdata_o(tbl_wdata_i));
   // 250 MHz clock
   initial begin
      ref_clk_i = 1'b0;
      forever #2 ref_clk_i = ~ref_clk_i;
   end
   // completion pulses counted, plus a hang guard well above the expected run
   always @(posedge ref_clk_i) begin
      if (nvm_irq_flag_o === 1'b1) irq_cnt++;
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         complete_run();
      end
   end
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // enable first, then start; poll start bit both ways; no array read till done
   task automatic run_op(input logic [15:0] c, input logic [23:0] a, input logic [15:0] d);
      int n;
      i_deenvm_core_model.tbl(1'b1, a, d);
      i_deenvm_core_model.unlock(c & 16'h7FFF);
      i_deenvm_core_model.unlock(c);
      n = 0;
      while (nvm_control_o[15] !== 1'b1 && n < 8) begin
         @(posedge ref_clk_i) #1 n++;
      end
      check("start set", {15'h0000, nvm_control_o[15]}, 16'h0001);
      n = 0;
      while (nvm_control_o[15] !== 1'b0 && n < 200) begin
         @(posedge ref_clk_i) #1 n++;
      end
      repeat (3) @(posedge ref_clk_i);
      #1 irq_exp++;
      check("control done", nvm_control_o, c & 16'h107F);
      check("irq count", 16'(irq_cnt), 16'(irq_exp));
      $display("test op %h done", c);
   endtask
   // read one word; hit says whether an answer is due
   task automatic rd(input logic [23:0] a, input logic [15:0] e, input logic hit);
      int n;
      logic seen;
      i_deenvm_core_model.tbl(1'b0, a, 16'h0000);
      n = 0;
      seen = 1'b0;
      #1;
      while (n < 3) begin
         if (tbl_rvalid_o === 1'b1) begin
            seen = 1'b1;
            check("read data", tbl_rdata_o, e);
         end
         @(posedge ref_clk_i) #1 n++;
      end
      check("read valid", {15'h0000, seen}, {15'h0000, hit});
   endtask
   initial begin
      rst_i = 1'b1;
      abort_reset_i = 1'b0;
      repeat (2) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      @(posedge ref_clk_i) #1;
      check("control reset", nvm_control_o, CONTROL_RESET);
      // no keys, then keys with a gap before the control write: both writes must bounce
      i_deenvm_core_model.sfr(SEL_CONTROL, 16'h4004);
      i_deenvm_core_model.idle();
      i_deenvm_core_model.sfr(SEL_KEY, KEY_FIRST);
      i_deenvm_core_model.sfr(SEL_KEY, KEY_SECOND);
      i_deenvm_core_model.idle();
      i_deenvm_core_model.sfr(SEL_CONTROL, 16'h4004);
      i_deenvm_core_model.idle();
      repeat (2) @(posedge ref_clk_i);
      #1 check("locked control", nvm_control_o, CONTROL_RESET);
      $display("test lock done");
      run_op(16'hC004, EE_BASE + 24'h5, 16'h1234);
      check("addr high", {8'h00, addr_high_o}, 16'h007F);
      check("addr low", addr_low_o, 16'hFE04);
      rd(EE_BASE + 24'h4, 16'h1234, 1'b1);
      run_op(16'hD004, EE_BASE + 24'h4, 16'h00FF);
      rd(EE_BASE + 24'h4, 16'h0034, 1'b1);
      run_op(16'hC004, EE_BASE + 24'h8, 16'h0000);
      run_op(16'hC059, EE_BASE, 16'h0000);
      rd(EE_BASE + 24'h4, 16'hFFFF, 1'b1);
      rd(EE_BASE + 24'h8, 16'h0000, 1'b1);
      run_op(16'hC05A, EE_BASE, 16'h0000);
      rd(EE_BASE + 24'h8, 16'hFFFF, 1'b1);
      run_op(16'hC004, EE_BASE + 24'h2, 16'h0000);
      run_op(16'hC004, EE_BASE + 24'h4, 16'h0000);
      run_op(16'hC058, EE_BASE + 24'h2, 16'h0000);
      rd(EE_BASE + 24'h2, 16'hFFFF, 1'b1);
      rd(EE_BASE + 24'h4, 16'h0000, 1'b1);
      run_op(16'hC051, EE_BASE + 24'h6, 16'h0000);
      rd(EE_BASE + 24'h4, 16'hFFFF, 1'b1);
      rd(EE_TOP, 16'hFFFF, 1'b1);
      rd(24'h000104, 16'h0000, 1'b0);
      // a reset pulse in mid-cycle must leave the error flag up
      i_deenvm_core_model.tbl(1'b1, EE_BASE + 24'h6, 16'h0000);
      i_deenvm_core_model.unlock(16'h4004);
      i_deenvm_core_model.unlock(16'hC004);
      repeat (3) @(posedge ref_clk_i);
      abort_reset_i <= 1'b1;
      @(posedge ref_clk_i) abort_reset_i <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
      #1 check("error flag", {15'h0000, nvm_control_o[13]}, 16'h0001);
      $display("test abort done");
      complete_run();
   end
endmodule
`default_nettype wire
